// *** hw/user_register_block.sv ***
// Register bank for the read/write test channels of a storage host core
`timescale 1ns/10ps

// Summary of operation
// - Eight read-only words of first-failure read data
// - 57-bit failure byte address over two words
// - 45-bit done counters per generator, split
// - Write start/length 48-bit, low/high write-only
// - Write command 010b pulses generator start
// - Pattern, verify enable, random mode drive generator
// - Seven-bit rate percent to write generator
// - Write status word packs core/generator state
// - Error vector and completion word read-only
// - Identify RAM readable at 0x2000/0x3000
// - Custom RAM read/write at 0x4000
// - Submission words out, completion words in
// - Timeout setting from write-only register
// - Link up and three-bit speed code
// - Lane width and training state in link
// - Disk size, capability, version read-only
// - Identify command forwarded, busy then polled
// - Identify data in RAM before idle
// - Read/write start raises both busy bits
// - Verify failure flag; run continues
// - Status busy bits follow core/generator
// - Read data valid three cycles later
module user_register_block #(
	parameter int RAM_WORDS = 2048,
	parameter int RAM_AW    = 11
) (
	input  wire logic                       ref_clk,
	input  wire logic                       resetn,
	input  wire logic [13:0]                reg_word_address,
	input  wire logic                       reg_write_strobe,
	input  wire logic [31:0]                reg_write_data,
	input  wire logic                       reg_read_request,
	output logic      [31:0]                reg_read_data,
	output logic                            reg_read_valid,
	input  wire test_regs_pkg::chan_status_s rd_status,
	input  wire test_regs_pkg::chan_status_s wr_status,
	input  wire logic                       rd_verify_fail,
	input  wire logic [255:0]               rd_fail_data,
	input  wire logic [56:0]                rd_fail_byte_addr,
	input  wire logic [44:0]                rd_done_count,
	input  wire logic [44:0]                wr_done_count,
	input  wire logic [31:0]                wr_error_vector,
	input  wire logic [31:0]                wr_io_completion_word,
	input  wire logic [15:0]                wr_debug_pins,
	input  wire logic [127:0]               custom_completion_dwords,
	input  wire test_regs_pkg::link_status_s link_state,
	input  wire logic [31:0]                capability_word,
	input  wire logic [47:0]                disk_block_count,
	input  wire logic [31:0]                core_version_word,
	input  wire logic                       ident_wr_en,
	input  wire logic [RAM_AW-1:0]          ident_wr_addr,
	input  wire logic [31:0]                ident_wr_data,
	input  wire logic                       custom_wr_en,
	input  wire logic [RAM_AW-1:0]          custom_wr_addr,
	input  wire logic [31:0]                custom_wr_data,
	output test_regs_pkg::wr_gen_cfg_s      wr_gen_cfg,
	output logic                            wr_gen_start,
	output logic                            rd_gen_start,
	output logic                            rd_core_cmd_request,
	output logic      [2:0]                 rd_core_cmd,
	output logic      [511:0]               custom_submission_dwords,
	output logic      [31:0]                timeout_setting
);

	// Window address slices must fit the 14-bit word address
	if (RAM_AW != 11 || RAM_WORDS != 2048) begin
		$error("user_register_block: RAM must be 2048 words");
	end

	// Read source chosen at request time, used one cycle later
	typedef enum logic [1:0] {SRC_REG, SRC_IDENT, SRC_CUSTOM} rd_src_e;

	// Decode helpers
	logic        wr_hit;               // Write strobe this cycle
	logic [15:0] byte_addr;            // Byte form of the word address
	logic        in_ident;             // Identify window
	logic        in_custom;            // Custom RAM window
	logic        in_subm;              // Submission word window
	logic        in_comp;              // Completion word window
	logic        in_fail;              // Failure data window

	assign wr_hit    = reg_write_strobe;
	assign byte_addr = {reg_word_address, 2'b00};
	assign in_ident  = byte_addr[15:13] == test_regs_pkg::OFF_IDENT_WIN[15:13];
	assign in_custom = byte_addr[15:13] == test_regs_pkg::OFF_CUSTOM_RAM[15:13];
	assign in_subm   = byte_addr[15:6] == test_regs_pkg::OFF_SUBM_WORDS[15:6];
	assign in_comp   = byte_addr[15:4] == test_regs_pkg::OFF_COMP_WORDS[15:4];
	assign in_fail   = byte_addr[15:5] == test_regs_pkg::OFF_RD_FAIL_DATA[15:5];

	// Capture state for the first verification failure
	logic         fail_seen_r;         // Sticky, cleared by a new read run
	logic [255:0] fail_data_r;         // Read data at the failure
	logic [56:0]  fail_addr_r;         // Byte address of the failure

	// Read pipeline
	logic [31:0]  reg_mux;             // Register file word, cycle 0
	logic [31:0]  reg_mux_r;           // Stage 1
	rd_src_e      src_r;               // Stage 1 source
	logic [31:0]  sel_r;               // Stage 2 selected word
	logic [1:0]   req_pipe_r;          // Request delay, stages 1-2
	logic [31:0]  ident_q;             // Identify RAM data
	logic [31:0]  custom_q;            // Custom RAM data

	// Status words as seen by software
	logic [31:0]  rd_status_word;
	logic [31:0]  wr_status_word;
	logic [31:0]  link_word;

	// Channel status packing
	always_comb begin
		rd_status_word = 32'h0000_0000;
		wr_status_word = 32'h0000_0000;
		wr_status_word[test_regs_pkg::STS_CORE_BUSY]  = wr_status.core_busy;
		wr_status_word[test_regs_pkg::STS_CORE_ERROR] = wr_status.core_error;
		wr_status_word[test_regs_pkg::STS_GEN_BUSY]   = wr_status.gen_busy;
		wr_status_word[11:4]  = wr_status.cur_id;
		wr_status_word[19:12] = wr_status.data_id;
		wr_status_word[28:20] = wr_status.queued;
		wr_status_word[test_regs_pkg::STS_CMD_READY]  = wr_status.cmd_ready;
		rd_status_word[test_regs_pkg::STS_CORE_BUSY]  = rd_status.core_busy;
		rd_status_word[test_regs_pkg::STS_CORE_ERROR] = rd_status.core_error;
		rd_status_word[test_regs_pkg::STS_GEN_BUSY]   = rd_status.gen_busy;
		rd_status_word[test_regs_pkg::STS_VERIFY_ERR] = fail_seen_r;
		rd_status_word[11:4]  = rd_status.cur_id;
		rd_status_word[19:12] = rd_status.data_id;
		rd_status_word[28:20] = rd_status.queued;
		rd_status_word[test_regs_pkg::STS_CMD_READY]  = rd_status.cmd_ready;
	end

	// Link status packing
	always_comb begin
		link_word = 32'h0000_0000;
		link_word[0]   = link_state.link_up;
		link_word[3:2] = link_state.speed[1:0];
		link_word[test_regs_pkg::LNK_SPEED_MSB] = link_state.speed[2];
		link_word[6:4]  = link_state.lane_width;
		link_word[13:8] = link_state.train_state;
	end

	// Register read mux; write-only and unmapped words read zero
	always_comb begin
		reg_mux = 32'h0000_0000;
		if (in_fail) begin
			reg_mux = fail_data_r[reg_word_address[2:0]*32 +: 32];
		end else if (in_comp) begin
			reg_mux = custom_completion_dwords[reg_word_address[1:0]*32 +: 32];
		end else begin
			case (byte_addr)
				test_regs_pkg::OFF_RD_STATUS:   reg_mux = rd_status_word;
				test_regs_pkg::OFF_RD_FAIL_LO:  reg_mux = fail_addr_r[31:0];
				test_regs_pkg::OFF_RD_FAIL_HI:  reg_mux = {7'h00, fail_addr_r[56:32]};
				test_regs_pkg::OFF_RD_CNT_LO:   reg_mux = rd_done_count[31:0];
				test_regs_pkg::OFF_RD_CNT_HI:   reg_mux = {19'h0, rd_done_count[44:32]};
				test_regs_pkg::OFF_WR_CNT_LO:   reg_mux = wr_done_count[31:0];
				test_regs_pkg::OFF_WR_CNT_HI:   reg_mux = {19'h0, wr_done_count[44:32]};
				test_regs_pkg::OFF_WR_STATUS:   reg_mux = wr_status_word;
				test_regs_pkg::OFF_WR_ERR_KIND: reg_mux = wr_error_vector;
				test_regs_pkg::OFF_WR_IO_COMP:  reg_mux = wr_io_completion_word;
				test_regs_pkg::OFF_WR_DEBUG_LO: reg_mux = {16'h0000, wr_debug_pins};
				test_regs_pkg::OFF_LINK_STATUS: reg_mux = link_word;
				test_regs_pkg::OFF_CAPABILITY:  reg_mux = capability_word;
				test_regs_pkg::OFF_DISK_LO:     reg_mux = disk_block_count[31:0];
				test_regs_pkg::OFF_DISK_HI:     reg_mux = {16'h0000, disk_block_count[47:32]};
				test_regs_pkg::OFF_VERSION:     reg_mux = core_version_word;
				default:                        reg_mux = 32'h0000_0000;
			endcase
		end
	end

	// Identify RAM: filled by the core, read-only to software
	// identify window
	word_ram #(.WORDS(RAM_WORDS), .AW(RAM_AW)) u_ident_ram (
		.ref_clk (ref_clk),
		.wr_en   (ident_wr_en),
		.wr_addr (ident_wr_addr),
		.wr_data (ident_wr_data),
		.rd_addr (reg_word_address[RAM_AW-1:0]),
		.rd_data (ident_q)
	);

	// Custom RAM write arbitration; core wins, a colliding CPU write drops
	logic              cram_we;
	logic [RAM_AW-1:0] cram_wa;
	logic [31:0]       cram_wd;

	always_comb begin
		cram_we = custom_wr_en | (wr_hit & in_custom);
		cram_wa = custom_wr_en ? custom_wr_addr
		                       : reg_word_address[RAM_AW-1:0];
		cram_wd = custom_wr_en ? custom_wr_data : reg_write_data;
	end

	word_ram #(.WORDS(RAM_WORDS), .AW(RAM_AW)) u_custom_ram (
		.ref_clk (ref_clk),
		.wr_en   (cram_we),
		.wr_addr (cram_wa),
		.wr_data (cram_wd),
		.rd_addr (reg_word_address[RAM_AW-1:0]),
		.rd_data (custom_q)
	);

	// Stage 1: latch mux and source; address is used in the request cycle only
	always_ff @(posedge ref_clk) begin
		reg_mux_r <= reg_mux;
		if (in_ident)
			src_r <= SRC_IDENT;
		else if (in_custom)
			src_r <= SRC_CUSTOM;
		else
			src_r <= SRC_REG;
	end

	// Stage 2: pick RAM or register word
	always_ff @(posedge ref_clk) begin
		case (src_r)
			SRC_IDENT:  sel_r <= ident_q;
			SRC_CUSTOM: sel_r <= custom_q;
			SRC_REG:    sel_r <= reg_mux_r;
			default:    sel_r <= 32'h0000_0000;
		endcase
	end

	// Stage 3 and valid: request delayed through three flops
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			req_pipe_r     <= 2'b00;
			reg_read_valid <= 1'b0;
			reg_read_data  <= 32'h0000_0000;
		end else begin
			req_pipe_r     <= {req_pipe_r[0], reg_read_request};
			reg_read_valid <= req_pipe_r[1];
			reg_read_data  <= sel_r;
		end
	end

	// Write channel settings
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			wr_gen_cfg <= '0;
		end else if (wr_hit) begin
			case (byte_addr)
				test_regs_pkg::OFF_WR_ADDR_LO:
					wr_gen_cfg.gen_start_address[31:0] <= reg_write_data;
				test_regs_pkg::OFF_WR_ADDR_HI:
					wr_gen_cfg.gen_start_address[47:32] <= reg_write_data[15:0];
				test_regs_pkg::OFF_WR_LEN_LO:
					wr_gen_cfg.gen_transfer_length[31:0] <= reg_write_data;
				test_regs_pkg::OFF_WR_LEN_HI:
					wr_gen_cfg.gen_transfer_length[47:32] <= reg_write_data[15:0];
				test_regs_pkg::OFF_WR_PATTERN: begin
					wr_gen_cfg.pattern     <= reg_write_data[2:0];
					wr_gen_cfg.verify_en   <= reg_write_data[test_regs_pkg::PAT_VERIFY];
					wr_gen_cfg.random_addr <= reg_write_data[test_regs_pkg::PAT_RANDOM];
				end
				test_regs_pkg::OFF_WR_RATE:
					wr_gen_cfg.gen_rate_percent <= reg_write_data[6:0];
				default: ;
			endcase
		end
	end

	// Command strobes: one-cycle pulses, reserved codes do nothing
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			wr_gen_start        <= 1'b0;
			rd_gen_start        <= 1'b0;
			rd_core_cmd_request <= 1'b0;
			rd_core_cmd         <= 3'h0;
		end else begin
			wr_gen_start <= wr_hit
				&& byte_addr == test_regs_pkg::OFF_WR_COMMAND
				&& reg_write_data[2:0] == test_regs_pkg::CMD_WRITE;
			rd_gen_start <= wr_hit
				&& byte_addr == test_regs_pkg::OFF_RD_COMMAND
				&& reg_write_data[2:0] == test_regs_pkg::CMD_READ;
			rd_core_cmd_request <= 1'b0;
			if (wr_hit && byte_addr == test_regs_pkg::OFF_RD_COMMAND) begin
				case (reg_write_data[2:0])
					test_regs_pkg::CMD_IDENTIFY,
					test_regs_pkg::CMD_SHUTDOWN,
					test_regs_pkg::CMD_SMART,
					test_regs_pkg::CMD_FLUSH: begin
						rd_core_cmd_request <= 1'b1;
						rd_core_cmd         <= reg_write_data[2:0];
					end
					test_regs_pkg::CMD_READ:
						rd_core_cmd <= reg_write_data[2:0];
					default: ;
				endcase
			end
		end
	end

	// Custom submission words and timeout
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			custom_submission_dwords <= '0;
			timeout_setting          <= 32'h0000_0000;
		end else if (wr_hit) begin
			if (in_subm)
				custom_submission_dwords[reg_word_address[3:0]*32 +: 32]
					<= reg_write_data;
			if (byte_addr == test_regs_pkg::OFF_TIMEOUT)
				timeout_setting <= reg_write_data;
		end
	end

	// First-failure capture; a failure in the start cycle still counts
	always_ff @(posedge ref_clk) begin
		if (!resetn) begin
			fail_seen_r <= 1'b0;
			fail_data_r <= '0;
			fail_addr_r <= '0;
		end else begin
			if (rd_verify_fail && (!fail_seen_r || rd_gen_start)) begin
				fail_seen_r <= 1'b1;
				fail_data_r <= rd_fail_data;
				fail_addr_r <= rd_fail_byte_addr;
			end else if (rd_gen_start) begin
				fail_seen_r <= 1'b0;
			end
		end
	end

	// Checks
	localparam logic [13:0] W_WR_CMD  = test_regs_pkg::OFF_WR_COMMAND[15:2];
	localparam logic [13:0] W_WR_STS  = test_regs_pkg::OFF_WR_STATUS[15:2];
	localparam logic [13:0] W_LINK    = test_regs_pkg::OFF_LINK_STATUS[15:2];
	localparam logic [13:0] W_TIMEOUT = test_regs_pkg::OFF_TIMEOUT[15:2];
	localparam logic [13:0] W_RD_CNTH = test_regs_pkg::OFF_RD_CNT_HI[15:2];

	property p_read_latency;
		@(posedge ref_clk) disable iff (!resetn)
		reg_read_request |-> ##3 reg_read_valid;
	endproperty
	a_read_latency: assert property (p_read_latency)
		else $error("read valid not three cycles after request");

	property p_no_spurious_valid;
		@(posedge ref_clk) disable iff (!resetn)
		!reg_read_request ##1 !reg_read_request ##1 !reg_read_request
			|=> !reg_read_valid;
	endproperty
	a_no_spurious_valid: assert property (p_no_spurious_valid)
		else $error("read valid without request");

	property p_wr_start;
		@(posedge ref_clk) disable iff (!resetn)
		(reg_write_strobe && reg_word_address == W_WR_CMD)
			|=> wr_gen_start == ($past(reg_write_data[2:0]) == 3'h2);
	endproperty
	a_wr_start: assert property (p_wr_start)
		else $error("write start pulse wrong for command code");

	property p_wr_status_read;
		@(posedge ref_clk) disable iff (!resetn)
		(reg_read_request && reg_word_address == W_WR_STS)
			|-> ##3 reg_read_data == $past(wr_status_word, 3);
	endproperty
	a_wr_status_read: assert property (p_wr_status_read)
		else $error("write status read returned wrong word");

	property p_link_read;
		@(posedge ref_clk) disable iff (!resetn)
		(reg_read_request && reg_word_address == W_LINK) |-> ##3
			(reg_read_data[0] == $past(link_state.link_up, 3)
			&& reg_read_data[16] == $past(link_state.speed[2], 3)
			&& reg_read_data[13:8] == $past(link_state.train_state, 3));
	endproperty
	a_link_read: assert property (p_link_read)
		else $error("link status fields misplaced");

	property p_unmapped_zero;
		@(posedge ref_clk) disable iff (!resetn)
		(reg_read_request && reg_word_address[13:11] == 3'h0
			&& reg_word_address[10:8] != 3'h0) |-> ##3 reg_read_data == 0;
	endproperty
	a_unmapped_zero: assert property (p_unmapped_zero)
		else $error("unmapped read not zero");

	property p_count_high;
		@(posedge ref_clk) disable iff (!resetn)
		(reg_read_request && reg_word_address == W_RD_CNTH) |-> ##3
			reg_read_data == {19'h0, $past(rd_done_count[44:32], 3)};
	endproperty
	a_count_high: assert property (p_count_high)
		else $error("done count high word wrong");

	property p_fail_hold;
		@(posedge ref_clk) disable iff (!resetn)
		(fail_seen_r && !rd_gen_start) |=> $stable(fail_data_r)
			&& $stable(fail_addr_r) && fail_seen_r;
	endproperty
	a_fail_hold: assert property (p_fail_hold)
		else $error("failure capture changed without new run");

	property p_timeout;
		@(posedge ref_clk) disable iff (!resetn)
		(reg_write_strobe && reg_word_address == W_TIMEOUT)
			|=> timeout_setting == $past(reg_write_data);
	endproperty
	a_timeout: assert property (p_timeout)
		else $error("timeout setting not loaded");

	c_wr_start: cover property (@(posedge ref_clk) wr_gen_start);
	c_rd_start: cover property (@(posedge ref_clk) rd_gen_start);
	c_fail: cover property (@(posedge ref_clk) rd_verify_fail && fail_seen_r);
	c_ident_read: cover property (@(posedge ref_clk)
		reg_read_request && in_ident ##3 reg_read_valid);

endmodule

// *** hw/test_regs_pkg.sv ***
// Package: register map, field layouts and carriers for the test register bank
package test_regs_pkg;

	// Byte offsets of the register map (word address = offset / 4)
	localparam logic [15:0] OFF_RD_COMMAND   = 16'h0010;
	localparam logic [15:0] OFF_RD_STATUS    = 16'h0100;
	localparam logic [15:0] OFF_RD_FAIL_DATA = 16'h0160;
	localparam logic [15:0] OFF_RD_FAIL_LO   = 16'h0180;
	localparam logic [15:0] OFF_RD_FAIL_HI   = 16'h0184;
	localparam logic [15:0] OFF_RD_CNT_LO    = 16'h0188;
	localparam logic [15:0] OFF_RD_CNT_HI    = 16'h018C;
	localparam logic [15:0] OFF_WR_ADDR_LO   = 16'h0200;
	localparam logic [15:0] OFF_WR_ADDR_HI   = 16'h0204;
	localparam logic [15:0] OFF_WR_LEN_LO    = 16'h0208;
	localparam logic [15:0] OFF_WR_LEN_HI    = 16'h020C;
	localparam logic [15:0] OFF_WR_COMMAND   = 16'h0210;
	localparam logic [15:0] OFF_WR_PATTERN   = 16'h0214;
	localparam logic [15:0] OFF_WR_RATE      = 16'h0218;
	localparam logic [15:0] OFF_WR_STATUS    = 16'h0300;
	localparam logic [15:0] OFF_WR_ERR_KIND  = 16'h0304;
	localparam logic [15:0] OFF_WR_IO_COMP   = 16'h030C;
	localparam logic [15:0] OFF_WR_DEBUG_LO  = 16'h0310;
	localparam logic [15:0] OFF_WR_CNT_LO    = 16'h0388;
	localparam logic [15:0] OFF_WR_CNT_HI    = 16'h038C;
	localparam logic [15:0] OFF_IDENT_WIN    = 16'h2000;
	localparam logic [15:0] OFF_CUSTOM_RAM   = 16'h4000;
	localparam logic [15:0] OFF_SUBM_WORDS   = 16'h6000;
	localparam logic [15:0] OFF_COMP_WORDS   = 16'h6100;
	localparam logic [15:0] OFF_TIMEOUT      = 16'h8000;
	localparam logic [15:0] OFF_LINK_STATUS  = 16'h8100;
	localparam logic [15:0] OFF_CAPABILITY   = 16'h8110;
	localparam logic [15:0] OFF_DISK_LO      = 16'h8120;
	localparam logic [15:0] OFF_DISK_HI      = 16'h8124;
	localparam logic [15:0] OFF_VERSION      = 16'h8200;

	// Command codes
	localparam logic [2:0] CMD_IDENTIFY = 3'h0;
	localparam logic [2:0] CMD_SHUTDOWN = 3'h1;
	localparam logic [2:0] CMD_WRITE    = 3'h2;
	localparam logic [2:0] CMD_READ     = 3'h3;
	localparam logic [2:0] CMD_SMART    = 3'h4;
	localparam logic [2:0] CMD_FLUSH    = 3'h6;

	// Field positions
	localparam int STS_CORE_BUSY  = 0;
	localparam int STS_CORE_ERROR = 1;
	localparam int STS_VERIFY_ERR = 2;
	localparam int STS_GEN_BUSY   = 3;
	localparam int STS_CMD_READY  = 31;
	localparam int PAT_VERIFY     = 3;
	localparam int PAT_RANDOM     = 4;
	localparam int LNK_SPEED_MSB  = 16;

	// Misc widths and counts
	localparam int FAIL_WORDS  = 8;
	localparam int SUBM_WORDS  = 16;
	localparam int COMP_WORDS  = 4;
	localparam int READ_STAGES = 3;

	// Status of one user channel, straight from the core and generator
	typedef struct packed {
		logic       cmd_ready;
		logic [8:0] queued;
		logic [7:0] data_id;
		logic [7:0] cur_id;
		logic       gen_busy;
		logic       core_error;
		logic       core_busy;
	} chan_status_s;

	// Link state from the PCIe block
	typedef struct packed {
		logic [5:0] train_state;
		logic [2:0] lane_width;
		logic [2:0] speed;
		logic       link_up;
	} link_status_s;

	// Write generator settings
	typedef struct packed {
		logic [47:0] gen_start_address;
		logic [47:0] gen_transfer_length;
		logic [2:0]  pattern;
		logic        verify_en;
		logic        random_addr;
		logic [6:0]  gen_rate_percent;
	} wr_gen_cfg_s;

endpackage

// *** hw/word_ram.sv ***
// One-write one-read word memory with registered read data
`timescale 1ns/10ps
module word_ram #(
	parameter int WORDS = 2048,
	parameter int AW    = 11
) (
	input  wire logic          ref_clk,
	input  wire logic          wr_en,
	input  wire logic [AW-1:0] wr_addr,
	input  wire logic [31:0]   wr_data,
	input  wire logic [AW-1:0] rd_addr,
	output logic      [31:0]   rd_data
);

	// Storage; contents are not reset, software reads after a fill
	logic [31:0] mem [WORDS];

	// Refuse sizes the address cannot cover, at elaboration
	if (WORDS < 2 || WORDS > (1 << AW)) begin
		$error("word_ram: WORDS does not fit AW");
	end

	// Write port
	always_ff @(posedge ref_clk) begin
		if (wr_en)
			mem[wr_addr] <= wr_data;
	end

	// Read port, one cycle of latency
	always_ff @(posedge ref_clk) begin
		rd_data <= mem[rd_addr];
	end

endmodule

// *** tb/far_side_model.sv ***
// Model of host core, generators and link beside the register bank
`timescale 1ns/10ps
module far_side_model (
	input  wire logic                   ref_clk,
	input  wire logic                   resetn,
	input  wire logic                   wr_gen_start,
	input  wire logic                   rd_gen_start,
	output test_regs_pkg::chan_status_s wr_status,
	output test_regs_pkg::chan_status_s rd_status,
	output test_regs_pkg::link_status_s link_state
);
	logic [5:0] wr_left_r; // Write run cycles left
	logic [5:0] rd_left_r; // Read run cycles left
	logic       up_r;      // Link trained
	// A start keeps core and generator busy 40 cycles
	always_ff @(posedge ref_clk) begin
		up_r <= resetn;
		if (!resetn || wr_gen_start)
			wr_left_r <= {6{resetn}} & 6'h28;
		else if (wr_left_r != 6'h00)
			wr_left_r <= wr_left_r - 6'h01;
		if (!resetn || rd_gen_start)
			rd_left_r <= {6{resetn}} & 6'h28;
		else if (rd_left_r != 6'h00)
			rd_left_r <= rd_left_r - 6'h01;
	end
	// Ids held steady so a status read is exact
	// Error rides with busy so status bit 1 is seen set and clear
	assign wr_status = {1'b1, 9'h0A5, 16'hC35A, {3{wr_left_r != 6'h00}}};
	assign rd_status = {1'b0, 9'h15A, 16'h3CA5, {3{rd_left_r != 6'h00}}};
	assign link_state = {6'h11, 3'h4, 3'h7, up_r};
endmodule

// *** tb/test_user_register_block.sv ***
// Self-checking bench for the test register bank
`timescale 1ns/10ps
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin \
	miscompares++; $display("[FAIL] %s exp %h got %h", n, e, a); end end
module test_user_register_block;
	logic ref_clk, resetn, reg_write_strobe, reg_read_request;
	logic reg_read_valid, rd_verify_fail, ident_wr_en, custom_wr_en;
	logic wr_gen_start, rd_gen_start, rd_core_cmd_request;
	logic [2:0] rd_core_cmd;
	logic [13:0] reg_word_address;
	logic [10:0] ident_wr_addr, custom_wr_addr;
	logic [31:0] reg_write_data, reg_read_data, wr_error_vector, r, seed;
	logic [31:0] wr_io_completion_word, capability_word, core_version_word;
	logic [31:0] ident_wr_data, custom_wr_data, timeout_setting;
	logic [255:0] rd_fail_data, fd;
	logic [56:0] rd_fail_byte_addr, fa;
	logic [44:0] rd_done_count, wr_done_count;
	logic [15:0] wr_debug_pins;
	logic [127:0] custom_completion_dwords;
	logic [47:0] disk_block_count;
	logic [511:0] custom_submission_dwords;
	logic [1023:0] blob; // Pool of random words
	test_regs_pkg::chan_status_s rd_status, wr_status;
	test_regs_pkg::link_status_s link_state;
	test_regs_pkg::wr_gen_cfg_s wr_gen_cfg;
	int miscompares = 0, comparisons = 0, starts = 0, s0, i, k;
	user_register_block u_user_register_block (.ref_clk, .resetn,
		.reg_word_address, .reg_write_strobe, .reg_write_data,
		.reg_read_request, .reg_read_data, .reg_read_valid, .rd_status,
		.wr_status, .rd_verify_fail, .rd_fail_data, .rd_fail_byte_addr,
		.rd_done_count, .wr_done_count, .wr_error_vector,
		.wr_io_completion_word, .wr_debug_pins, .custom_completion_dwords,
		.link_state, .capability_word, .disk_block_count, .core_version_word,
		.ident_wr_en, .ident_wr_addr, .ident_wr_data, .custom_wr_en,
		.custom_wr_addr, .custom_wr_data, .wr_gen_cfg, .wr_gen_start,
		.rd_gen_start, .rd_core_cmd_request, .rd_core_cmd,
		.custom_submission_dwords, .timeout_setting);
	far_side_model u_far_side_model (.ref_clk, .resetn, .wr_gen_start,
		.rd_gen_start, .wr_status, .rd_status, .link_state);
	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk)
		if (wr_gen_start === 1'b1)
			starts++;
	function automatic logic [31:0] rnd();
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed;
	endfunction
	// Expected link status word from the link fields
	function automatic logic [31:0] exp_link(test_regs_pkg::link_status_s l);
		return {15'h0, l.speed[2], 2'h0, l.train_state, 1'b0, l.lane_width,
			l.speed[1:0], 1'b0, l.link_up};
	endfunction
	task automatic end_of_test();
		$display("comparisons %0d miscompares %0d", comparisons, miscompares);
		if (miscompares == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task automatic wr(input logic [15:0] a, input logic [31:0] d);
		@(negedge ref_clk);
		reg_word_address = a[15:2];
		reg_write_data = d;
		reg_write_strobe = 1'b1;
		@(negedge ref_clk);
		reg_write_strobe = 1'b0;
	endtask
	task automatic rd(input logic [15:0] a, output logic [31:0] d);
		@(negedge ref_clk);
		reg_word_address = a[15:2];
		reg_read_request = 1'b1;
		@(negedge ref_clk);
		reg_read_request = 1'b0;
		repeat (2) @(negedge ref_clk);
		`CHK("valid", 1'b1, reg_read_valid)
		d = reg_read_data;
	endtask
	task automatic rc(input string n, input logic [15:0] a,
		input logic [31:0] e);
		logic [31:0] d;
		rd(a, d);
		`CHK(n, e, d)
	endtask
	task automatic pulse_fail();
		@(negedge ref_clk);
		rd_verify_fail = 1'b1;
		@(negedge ref_clk);
		rd_verify_fail = 1'b0;
	endtask
	initial begin
		seed = 32'hE14E4936;
		{resetn, reg_word_address, reg_write_strobe, reg_read_request} = '0;
		{rd_verify_fail, ident_wr_en, custom_wr_en, ident_wr_addr} = '0;
		custom_wr_addr = 11'h000;
		for (i = 0; i < 32; i++)
			blob = {blob[991:0], rnd()};
		{rd_fail_data, rd_fail_byte_addr, rd_done_count, wr_done_count,
			wr_error_vector, wr_io_completion_word, wr_debug_pins,
			custom_completion_dwords, capability_word, disk_block_count,
			core_version_word, ident_wr_data, custom_wr_data,
			reg_write_data} = blob[818:0];
		repeat (8) @(negedge ref_clk);
		resetn = 1'b1;
		for (i = 0; i < 50 && link_state.link_up !== 1'b1; i++)
			@(negedge ref_clk);
		// Link never came up: count it and go to the report
		if (link_state.link_up !== 1'b1) begin
			miscompares++;
			end_of_test();
		end
		rc("link", 16'h8100, exp_link(link_state));
		rc("unmapped", 16'h0400, 32'h0);
		rc("wo read", 16'h0200, 32'h0);
		for (k = 0; k < 5; k++) begin
			r = rnd();
			wr(16'h0214, {r[31:3], k[2:0]});
			`CHK("pattern", {k[2:0], r[3], r[4]}, wr_gen_cfg[11:7])
		end
		for (k = 0; k < 5; k++)
			wr(16'h0200 + 16'(4 * k), blob[k*32+:32]);
		wr(16'h0218, blob[159:128]);
		`CHK("start", blob[47:0], wr_gen_cfg.gen_start_address)
		`CHK("len", blob[111:64], wr_gen_cfg.gen_transfer_length)
		`CHK("rate", blob[134:128], wr_gen_cfg.gen_rate_percent)
		for (k = 7; k >= 0; k--) begin
			s0 = starts;
			wr(16'h0210, {29'h0, k[2:0]});
			repeat (3) @(negedge ref_clk);
			`CHK("starts", k == 2, starts - s0)
		end
		rc("wr status", 16'h0300, {1'b1, 2'h0, 9'h0A5, 16'hC35A, 4'hB});
		rd(16'h0300, r);
		`CHK("busy on", 2'b11, {r[3], r[0]})
		repeat (40) @(negedge ref_clk);
		rd(16'h0300, r);
		`CHK("busy off", 2'b00, {r[3], r[0]})
		rc("err", 16'h0304, wr_error_vector);
		rc("io", 16'h030C, wr_io_completion_word);
		rc("cnt lo", 16'h0388, wr_done_count[31:0]);
		rc("cnt hi", 16'h018C, {19'h0, rd_done_count[44:32]});
		rc("cap", 16'h8110, capability_word);
		rc("disk hi", 16'h8124, {16'h0, disk_block_count[47:32]});
		wr(16'h8200, ~core_version_word);
		rc("version", 16'h8200, core_version_word);
		for (k = 0; k < 16; k++) begin
			wr(16'h6000 + 16'(4 * k), blob[k*32+:32]);
			`CHK("subm", blob[k*32+:32], custom_submission_dwords[k*32+:32])
		end
		rc("comp", 16'h610C, custom_completion_dwords[127:96]);
		wr(16'h8000, blob[543:512]);
		`CHK("timeout", blob[543:512], timeout_setting)
		fd = rd_fail_data;
		fa = rd_fail_byte_addr;
		pulse_fail();
		{rd_fail_data, rd_fail_byte_addr} = ~{fd, fa};
		pulse_fail();
		for (k = 0; k < 8; k++)
			rc("fail word", 16'h0160 + 16'(4 * k), fd[k*32+:32]);
		rc("fail lo", 16'h0180, fa[31:0]);
		rc("fail hi", 16'h0184, {7'h0, fa[56:32]});
		rd(16'h0100, r);
		`CHK("verify", 1'b1, r[2])
		wr(16'h0010, 32'h3);
		pulse_fail();
		rc("fail new", 16'h0160, rd_fail_data[31:0]);
		rd(16'h0100, r);
		`CHK("rd busy", 2'b11, {r[3], r[0]})
		wr(16'h0010, 32'h0);
		`CHK("ident cmd", 4'h8, {rd_core_cmd_request, rd_core_cmd})
		ident_wr_addr = 11'h400;
		ident_wr_en = 1'b1;
		@(negedge ref_clk);
		ident_wr_en = 1'b0;
		rc("ident", 16'h3000, ident_wr_data);
		wr(16'h4008, blob[575:544]);
		rc("custom", 16'h4008, blob[575:544]);
		end_of_test();
	end
endmodule
